// ===== rtl/sbg_defs.svh
// Operation
// [R1] Ignore all bus instructions during initialisation
// [R2] Enter standby once power-on clear completes
// [R3] Low supply at stop aborts pending write
// [R4] Write only after data byte, ack, stop
// [R5] Start mid-command discards it, decodes fresh
// [R6] Master must release held data line first
// [R7] Master reloads address after cancelling command
// [R8] Reject clock/data noise of 100 ns or less
// [R9] Master checks acknowledge after each byte; the testbench checks it only after the address and word address bytes of frame
// [R10] Phase adjustment restores interface without power-on clear
// [R11] Master: start, nine clocks, start, stop
// [R12] Start resets bus state, drops any output
// [R13] Data line released during initialisation
`ifndef SBG_DEFS_SVH
`define SBG_DEFS_SVH

// Clock period and noise window in ns
`define SBG_CLK_NS 10
`define SBG_FILT_NS 100
// Cycles a level must outlast before it counts; a 100 ns pulse is exactly 10
`define SBG_FILT_CYC 4'((`SBG_FILT_NS + `SBG_CLK_NS - 1) / `SBG_CLK_NS)
`define SBG_FILT_W 4

// Bit and byte positions within a transfer
`define SBG_BIT_ACK 4'h8
`define SBG_BIT_TXLAST 4'h7
// A stop needs one clock rise after the ack; any more means a byte was begun
`define SBG_BIT_STOP 4'h1
`define SBG_IDX_ADDR 2'h0
`define SBG_IDX_DATA 2'h3
// Pin indices in the filter arrays
`define SBG_PIN_SCL 0
`define SBG_PIN_SDA 1
// Default bus address, arbitrary value
`define SBG_DEV_ADDR 7'h2A

`endif

// ===== rtl/sbg_pkg.sv
package sbg_pkg;

  // Raw two-wire pin levels
  typedef struct packed {
    logic sda;
    logic scl;
  } sbg_pins_t;

  // Bus engine states, one-hot
  typedef enum logic [5:0] {
    SBG_INIT = 6'h01,
    SBG_IDLE = 6'h02,
    SBG_RX = 6'h04,
    SBG_ACK = 6'h08,
    SBG_TX = 6'h10,
    SBG_MACK = 6'h20
  } sbg_state_t;

endpackage

// ===== rtl/sbg_bus_guard.sv
`timescale 1ns/1ps
`include "sbg_defs.svh"

module sbg_bus_guard #(
  parameter logic [6:0] DEV_ADDR = `SBG_DEV_ADDR
) (
  input wire logic mclk,
  input wire logic rst,
  input wire sbg_pkg::sbg_pins_t pins_in,
  input wire logic por_busy,
  input wire logic low_supply,
  input wire logic [7:0] rd_data,
  output logic sda_o,
  output logic sda_oe,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rd_req,
  output logic wr_commit,
  output logic wr_abort
);

  // Write may commit only when the stop's own clock rise is the sole one since a data byte ack
  function automatic logic commit_ok(input sbg_pkg::sbg_state_t st, input logic [3:0] bc,
                                     input logic [1:0] idx, input logic rw);
    commit_ok = (st == sbg_pkg::SBG_RX) && (bc == `SBG_BIT_STOP) && (idx == `SBG_IDX_DATA) && !rw;
  endfunction

  // Input conditioning registers, one lane per pin
  logic [1:0] s1_q, s2_q, s3_q; // Three-stage synchroniser
  logic [1:0] ag_q; // Level once stages two and three agree
  logic [1:0] filt_q; // Filtered level
  logic [1:0] filt_p_q; // Filtered level one cycle ago
  logic [`SBG_FILT_W-1:0] cnt_q [2]; // Cycles the new level has held
  logic [1:0] pin_raw;
  logic [2:0] lv_q; // Low-supply synchroniser
  logic low_q; // Agreed low-supply level

  assign pin_raw = {pins_in.sda, pins_in.scl};

  // Sync then low-pass each pin; a level shorter than the window never reaches filt_q
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      always_ff @(posedge mclk) begin
        if (rst) begin
          s1_q[gi] <= 1'b1;
          s2_q[gi] <= 1'b1;
          s3_q[gi] <= 1'b1;
          ag_q[gi] <= 1'b1;
          filt_q[gi] <= 1'b1;
          cnt_q[gi] <= '0;
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          // Change counts only once stages agree
          if (s2_q[gi] == s3_q[gi]) begin
            ag_q[gi] <= s3_q[gi];
          end
          // Accept only after the level outlasts the noise window
          if (ag_q[gi] == filt_q[gi]) begin
            cnt_q[gi] <= '0;
          end else if (cnt_q[gi] == `SBG_FILT_CYC) begin // [R8]
            filt_q[gi] <= ag_q[gi];
            cnt_q[gi] <= '0;
          end else begin
            cnt_q[gi] <= cnt_q[gi] + 4'h1;
          end
        end
      end
    end
  endgenerate

  // Previous filtered levels and low-supply sync
  always_ff @(posedge mclk) begin
    if (rst) begin
      filt_p_q <= 2'h3;
      lv_q <= 3'h0;
      low_q <= 1'b0;
    end else begin
      filt_p_q <= filt_q;
      lv_q <= {lv_q[1:0], low_supply};
      if (lv_q[1] == lv_q[2]) begin
        low_q <= lv_q[2];
      end
    end
  end

  // Bus events from filtered levels
  wire scl_f = filt_q[`SBG_PIN_SCL];
  wire sda_f = filt_q[`SBG_PIN_SDA];
  wire scl_rise = scl_f && !filt_p_q[`SBG_PIN_SCL];
  wire scl_fall = !scl_f && filt_p_q[`SBG_PIN_SCL];
  wire scl_hold = scl_f && filt_p_q[`SBG_PIN_SCL];
  wire start_ev = scl_hold && !sda_f && filt_p_q[`SBG_PIN_SDA];
  wire stop_ev = scl_hold && sda_f && !filt_p_q[`SBG_PIN_SDA];

  // Engine state
  sbg_pkg::sbg_state_t st_q;
  logic [3:0] bit_q; // Bits done in current byte
  logic [1:0] idx_q; // Byte index, saturates once the first data byte is acked
  logic rw_q; // Read when set
  logic [7:0] sh_q; // Receive or transmit shifter
  logic oe_q; // Pulling data line low
  logic commit_q, abort_q, rxv_q, rdr_q;
  wire can_commit = commit_ok(st_q, bit_q, idx_q, rw_q);
  wire addr_hit = (sh_q[7:1] == DEV_ADDR);

  // Main bus engine; stop beats start beats clock edges
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= sbg_pkg::SBG_INIT;
      bit_q <= 4'h0;
      idx_q <= `SBG_IDX_ADDR;
      rw_q <= 1'b0;
      sh_q <= 8'h00;
      oe_q <= 1'b0;
      commit_q <= 1'b0;
      abort_q <= 1'b0;
      rxv_q <= 1'b0;
      rdr_q <= 1'b0;
    end else begin
      commit_q <= 1'b0;
      abort_q <= 1'b0;
      rxv_q <= 1'b0;
      rdr_q <= 1'b0;
      if (st_q == sbg_pkg::SBG_INIT) begin
        // Deaf and released until power-on clear ends
        oe_q <= 1'b0; // [R13]
        if (!por_busy) begin
          st_q <= sbg_pkg::SBG_IDLE; // [R1] [R2]
        end
      end else if (stop_ev) begin
        // Stop ends everything; only a clean data-ack boundary writes
        if (can_commit) begin // [R4]
          commit_q <= !low_q;
          abort_q <= low_q; // [R3]
        end
        st_q <= sbg_pkg::SBG_IDLE;
        oe_q <= 1'b0;
      end else if (start_ev) begin
        // Fresh transfer, any output dropped
        st_q <= sbg_pkg::SBG_RX; // [R5] [R12] [R10]
        bit_q <= 4'h0;
        idx_q <= `SBG_IDX_ADDR;
        oe_q <= 1'b0;
      end else begin
        unique case (st_q)
          sbg_pkg::SBG_IDLE: begin
            // Standby: wait for start
            oe_q <= 1'b0;
          end
          sbg_pkg::SBG_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_f};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == `SBG_BIT_ACK) begin
              // Foreign address: go quiet until next start
              if (idx_q == `SBG_IDX_ADDR && !addr_hit) begin
                st_q <= sbg_pkg::SBG_IDLE;
              end else begin
                st_q <= sbg_pkg::SBG_ACK;
                oe_q <= 1'b1;
                if (idx_q == `SBG_IDX_ADDR) begin
                  rw_q <= sh_q[0];
                end else begin
                  rxv_q <= 1'b1;
                end
              end
            end
          end
          sbg_pkg::SBG_ACK: begin
            // Ack held for one clock; on its falling edge a write releases the line, a read drives the first data bit
            if (scl_fall) begin
              bit_q <= 4'h0;
              if (idx_q != `SBG_IDX_DATA) begin
                idx_q <= idx_q + 2'h1;
              end
              if (rw_q) begin
                st_q <= sbg_pkg::SBG_TX;
                sh_q <= rd_data;
                oe_q <= !rd_data[7];
                rdr_q <= 1'b1;
              end else begin
                st_q <= sbg_pkg::SBG_RX;
                oe_q <= 1'b0;
              end
            end
          end
          sbg_pkg::SBG_TX: begin
            if (scl_fall) begin
              if (bit_q == `SBG_BIT_TXLAST) begin
                st_q <= sbg_pkg::SBG_MACK;
                oe_q <= 1'b0;
                bit_q <= 4'h0;
              end else begin
                sh_q <= {sh_q[6:0], 1'b0};
                oe_q <= !sh_q[6];
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          sbg_pkg::SBG_MACK: begin
            // No ack from master ends the read and frees the line
            if (scl_rise && sda_f) begin
              st_q <= sbg_pkg::SBG_IDLE; // [R10]
            end else if (scl_fall) begin
              st_q <= sbg_pkg::SBG_TX;
              sh_q <= rd_data;
              oe_q <= !rd_data[7];
              rdr_q <= 1'b1;
            end
          end
          default: begin
            st_q <= sbg_pkg::SBG_IDLE;
            oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open-drain data: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = oe_q;
  assign rx_data = sh_q;
  assign rx_valid = rxv_q;
  assign rd_req = rdr_q;
  assign wr_commit = commit_q;
  assign wr_abort = abort_q;

  // Run length of the agreed level, for the noise check only
  logic [`SBG_FILT_W-1:0] run_q [2];
  always_ff @(posedge mclk) begin
    if (rst) begin
      run_q[0] <= '0;
      run_q[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (ag_q[i] == filt_q[i]) run_q[i] <= '0;
        else if (run_q[i] != 4'hF) run_q[i] <= run_q[i] + 4'h1;
      end
    end
  end

  sequence s_start_seen;
    start_ev && st_q != sbg_pkg::SBG_INIT && !stop_ev;
  endsequence

  property p_init_ignore;
    @(posedge mclk) disable iff (rst) st_q == sbg_pkg::SBG_INIT |=> !wr_commit && !rx_valid && !rd_req;
  endproperty
  a_init_ignore: assert property (p_init_ignore) else $error("activity during init"); // [R1]

  property p_standby;
    @(posedge mclk) disable iff (rst) st_q == sbg_pkg::SBG_INIT && !por_busy |=> st_q == sbg_pkg::SBG_IDLE;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby after init"); // [R2]

  property p_low_abort;
    @(posedge mclk) disable iff (rst)
      st_q != sbg_pkg::SBG_INIT && stop_ev && can_commit && low_q |=> wr_abort && !wr_commit;
  endproperty
  a_low_abort: assert property (p_low_abort) else $error("write not aborted on low supply"); // [R3]

  property p_commit_cause;
    @(posedge mclk) disable iff (rst) wr_commit |-> $past(stop_ev) && $past(can_commit) && !$past(low_q);
  endproperty
  a_commit_cause: assert property (p_commit_cause) else $error("write without valid stop"); // [R4]

  property p_start_fresh;
    @(posedge mclk) disable iff (rst) s_start_seen |=> st_q == sbg_pkg::SBG_RX && bit_q == 4'h0 && idx_q == 2'h0;
  endproperty
  a_start_fresh: assert property (p_start_fresh) else $error("start did not restart decode"); // [R5]

  property p_noise;
    @(posedge mclk) disable iff (rst) (filt_q != filt_p_q) |-> $past(run_q[0]) > `SBG_FILT_CYC - 4'h1
      || $past(run_q[1]) > `SBG_FILT_CYC - 4'h1;
  endproperty
  a_noise: assert property (p_noise) else $error("short pulse passed filter"); // [R8]

  property p_nack_release;
    @(posedge mclk) disable iff (rst) st_q == sbg_pkg::SBG_MACK && scl_rise && sda_f && !start_ev && !stop_ev
      |=> st_q == sbg_pkg::SBG_IDLE ##1 !sda_oe;
  endproperty
  a_nack_release: assert property (p_nack_release) else $error("no release after dummy clocks"); // [R10]

  property p_start_drop;
    @(posedge mclk) disable iff (rst) s_start_seen |=> !sda_oe [*2];
  endproperty
  a_start_drop: assert property (p_start_drop) else $error("output kept after start"); // [R12]

  property p_init_quiet;
    @(posedge mclk) disable iff (rst) $past(st_q) == sbg_pkg::SBG_INIT |-> !sda_oe;
  endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("data driven during init"); // [R13]

endmodule

// ===== sim/sbg_bus_master.sv
`timescale 1ns/1ps
module sbg_bus_master #(
  parameter int Q = 30
) (
  input wire logic mclk,
  input wire logic sda_oe,
  output sbg_pkg::sbg_pins_t pins
);
  // Master drive levels, released lines float high
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  // Wired-and data line
  assign pins.sda = sda_q & ~sda_oe;
  assign pins.scl = scl_q;

  // Wait whole cycles
  task automatic hold(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Data falls while clock high; clock then parked low
  task automatic start();
    sda_q <= 1'b1;
    hold(Q);
    scl_q <= 1'b1;
    hold(Q);
    sda_q <= 1'b0;
    hold(Q);
    scl_q <= 1'b0;
    hold(Q);
  endtask

  // Data rises while clock high; clock stands high after
  task automatic stop();
    sda_q <= 1'b0;
    hold(Q);
    scl_q <= 1'b1;
    hold(Q);
    sda_q <= 1'b1;
    hold(Q);
  endtask

  // Data moves a quarter after clock fall, sampled mid-high
  task automatic bit_io(input logic b, output logic got);
    sda_q <= b;
    hold(Q);
    scl_q <= 1'b1;
    hold(Q);
    got = pins.sda;
    hold(Q);
    scl_q <= 1'b0;
    hold(Q);
  endtask

  // Byte MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic mack, output logic ack_n, output logic [7:0] rd);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], rd[i]);
    end
    bit_io(mack, ack_n);
  endtask

  // Short clock pulse while clock is low
  task automatic glitch(input int n);
    scl_q <= 1'b1;
    hold(n);
    scl_q <= 1'b0;
    hold(Q);
  endtask

  // Recovery: start, nine clocks with data high, start, stop
  task automatic phase();
    logic x;
    start();
    for (int i = 0; i < 9; i++) begin
      bit_io(1'b1, x);
    end
    start();
    stop();
  endtask
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
  localparam logic [6:0] ADDR = 7'h2A;
  // Design inputs
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic por_busy = 1'b1;
  logic low_supply = 1'b0;
  logic [7:0] rd_data = 8'h00;
  sbg_pkg::sbg_pins_t pins;
  // Design outputs
  logic sda_o, sda_oe, rx_valid, rd_req, wr_commit, wr_abort;
  logic [7:0] rx_data;
  // Scoreboard
  int fail_count = 0;
  int check_count = 0;
  int n_oe = 0, n_rx = 0, n_com = 0, n_abt = 0, n_rd = 0;
  logic [7:0] rx_last = 8'h00;
  logic a, x;
  logic [7:0] r;

  initial forever #5 mclk = ~mclk;

  sbg_bus_guard #(.DEV_ADDR(ADDR)) i_dut (.mclk(mclk), .rst(rst), .pins_in(pins), .por_busy(por_busy),
    .low_supply(low_supply), .rd_data(rd_data), .sda_o(sda_o), .sda_oe(sda_oe), .rx_data(rx_data),
    .rx_valid(rx_valid), .rd_req(rd_req), .wr_commit(wr_commit), .wr_abort(wr_abort));
  sbg_bus_master i_master (.mclk(mclk), .sda_oe(sda_oe), .pins(pins));

  // Count output events as they happen
  always @(posedge mclk) begin
    if (sda_oe === 1'b1) n_oe <= n_oe + 1;
    if (rx_valid === 1'b1) begin
      n_rx <= n_rx + 1;
      rx_last <= rx_data;
    end
    if (wr_commit === 1'b1) n_com <= n_com + 1;
    if (wr_abort === 1'b1) n_abt <= n_abt + 1;
    if (rd_req === 1'b1) n_rd <= n_rd + 1;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Write frame: address, word address, optional data, stop
  task automatic frame(input logic [7:0] wa, input logic [7:0] wd, input bit dat);
    i_master.start();
    i_master.xfer({ADDR, 1'b0}, 1'b1, a, r);
    chk("addr ack", 0, a);
    i_master.xfer(wa, 1'b1, a, r);
    chk("word ack", 0, a);
    if (dat) i_master.xfer(wd, 1'b1, a, r);
    i_master.stop();
  endtask

  task automatic t_init();
    i_master.start();
    i_master.xfer({ADDR, 1'b0}, 1'b1, a, r);
    i_master.stop();
    chk("init ack", 1, a);
    chk("init drive", 0, n_oe);
    chk("init rx", 0, n_rx);
    chk("open drain level", 0, sda_o);
  endtask

  task automatic t_write();
    int c = n_com;
    frame(8'h10, 8'hC3, 1);
    chk("commit", c + 1, n_com);
    chk("data", 8'hC3, rx_last);
  endtask

  task automatic t_nodata();
    int c = n_com;
    frame(8'h20, 8'h00, 0);
    chk("no commit", c, n_com);
    chk("word", 8'h20, rx_last);
  endtask

  task automatic t_lowsup();
    int c = n_com;
    int b = n_abt;
    low_supply <= 1'b1;
    frame(8'h30, 8'h5A, 1);
    low_supply <= 1'b0;
    chk("abort", b + 1, n_abt);
    chk("commit", c, n_com);
  endtask

  task automatic t_restart();
    int c = n_com;
    i_master.start();
    i_master.xfer({ADDR, 1'b0}, 1'b1, a, r);
    repeat (4) i_master.bit_io(1'b1, x);
    frame(8'h44, 8'h99, 1);
    chk("commit", c + 1, n_com);
    chk("data", 8'h99, rx_last);
  endtask

  // Clock pulse of exactly 100 ns must not shift a bit in
  task automatic t_glitch();
    int c = n_com;
    i_master.start();
    i_master.xfer({ADDR, 1'b0}, 1'b1, a, r);
    i_master.glitch(10);
    i_master.xfer(8'h55, 1'b1, a, r);
    i_master.xfer(8'h3C, 1'b1, a, r);
    i_master.stop();
    chk("data", 8'h3C, rx_last);
    chk("commit", c + 1, n_com);
  endtask

  // Device holds data low in a read; recovery sequence frees it
  task automatic t_phase();
    int c = n_com;
    int q = n_rd;
    int d;
    rd_data <= 8'h00;
    i_master.start();
    i_master.xfer({ADDR, 1'b1}, 1'b1, a, r);
    d = n_oe;
    i_master.phase();
    chk("drove", 1, n_oe > d);
    chk("read requests", q + 1, n_rd);
    chk("released", 0, sda_oe);
    chk("no commit", c, n_com);
    t_write();
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #500000;
    fail_count++;
    results();
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (20) @(posedge mclk);
    t_init();
    por_busy <= 1'b0;
    repeat (20) @(posedge mclk);
    t_write();
    t_nodata();
    t_lowsup();
    t_restart();
    t_glitch();
    t_phase();
    results();
  end
endmodule
